//--- rtl/asp_host.sv
`timescale 1ns/10ps
`include "asp_params.svh"

// Overview of operation
// - Read: strobe high, select and enable low.
// - Accesses spaced 85 ns; data valid then.
// - Strobe low 60 ns, select 65 ns.
// - Drive write data only after 30 ns.
// - Retention: select high, then one read cycle.
module asp_host (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET_N,
  input  wire logic                  REQ_VALID,
  input  wire logic                  REQ_WRITE,
  input  wire logic [`ASP_ADDR_W-1:0] REQ_ADDR,
  input  wire logic [`ASP_DATA_W-1:0] REQ_WDATA,
  output logic                       REQ_READY,
  output logic                       RSP_VALID,
  output logic [`ASP_DATA_W-1:0]     RSP_RDATA,
  input  wire logic                  RETAIN_REQ,
  output logic                       RETAIN_ACTIVE,
  output logic [`ASP_ADDR_W-1:0]     WORD_ADDRESS,
  output logic                       CHIP_SEL_N,
  output logic                       OUT_EN_N,
  output logic                       WRITE_N,
  input  wire logic [`ASP_DATA_W-1:0] BYTE_LINES_IN,
  output logic [`ASP_DATA_W-1:0]     BYTE_LINES_OUT,
  output logic                       BYTE_LINES_OE
);

  // ===================================================================
  // State and sequencing.
  // ===================================================================
  asp_pkg::asp_state_t   state;
  asp_pkg::asp_state_t   next_state;
  logic                  last;
  logic                  tmr_load;
  logic [`ASP_CNT_W-1:0] tmr_val;
  logic [`ASP_ADDR_W-1:0] addr;
  logic [`ASP_DATA_W-1:0] wdata;

  wire take_req = (state == asp_pkg::ASP_IDLE) && REQ_VALID && REQ_READY;
  wire rd_done  = (state == asp_pkg::ASP_READ) && last;

  always_comb begin
    next_state = state;
    unique case (state)
      asp_pkg::ASP_IDLE: begin
        if (take_req) begin
          next_state = REQ_WRITE ? asp_pkg::ASP_WR_SET : asp_pkg::ASP_READ;
        end else if (RETAIN_REQ) begin
          next_state = asp_pkg::ASP_RETAIN;
        end
      end
      asp_pkg::ASP_READ: begin
        if (last) begin
          next_state = asp_pkg::ASP_IDLE;
        end
      end
      asp_pkg::ASP_WR_SET: begin
        if (last) begin
          next_state = asp_pkg::ASP_WR_DATA;
        end
      end
      asp_pkg::ASP_WR_DATA: begin
        if (last) begin
          next_state = asp_pkg::ASP_WR_END;
        end
      end
      asp_pkg::ASP_WR_END: begin
        if (last) begin
          next_state = asp_pkg::ASP_IDLE;
        end
      end
      asp_pkg::ASP_RETAIN: begin
        if (!RETAIN_REQ) begin
          next_state = asp_pkg::ASP_RECOVER;
        end
      end
      asp_pkg::ASP_RECOVER: begin
        if (last) begin
          next_state = asp_pkg::ASP_IDLE;
        end
      end
      default: begin
        next_state = asp_pkg::ASP_IDLE;
      end
    endcase
  end

  // Each timed state loads its own length on entry.
  assign tmr_load = (next_state != state);
  assign tmr_val  =
    (next_state == asp_pkg::ASP_READ)    ? `ASP_CNT_W'(`ASP_RD_CYC) :
    (next_state == asp_pkg::ASP_WR_SET)  ? `ASP_CNT_W'(`ASP_WZ_CYC) :
    (next_state == asp_pkg::ASP_WR_DATA) ? `ASP_CNT_W'(`ASP_WD_CYC) :
    (next_state == asp_pkg::ASP_WR_END)  ? `ASP_CNT_W'(`ASP_WE_CYC) :
    (next_state == asp_pkg::ASP_RECOVER) ? `ASP_CNT_W'(`ASP_RC_CYC) :
                                           `ASP_CNT_W'(1);

  asp_cycle_timer u_timer (
    .clk      (CLK_SYS),
    .rst_n    (RESET_N),
    .load     (tmr_load),
    .load_val (tmr_val),
    .last     (last)
  );

  // ===================================================================
  // Pin decode from the next state.
  // ===================================================================
  wire next_rd    = (next_state == asp_pkg::ASP_READ);
  wire next_wlow  = (next_state == asp_pkg::ASP_WR_SET) ||
                    (next_state == asp_pkg::ASP_WR_DATA);
  wire next_drive = (next_state == asp_pkg::ASP_WR_DATA) ||
                    (next_state == asp_pkg::ASP_WR_END);
  wire next_sel   = next_rd || next_wlow;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= asp_pkg::ASP_IDLE;
      addr  <= 15'h0000;
      wdata <= 8'h00;
    end else begin
      state <= next_state;
      if (take_req) begin
        addr  <= REQ_ADDR;
        wdata <= REQ_WDATA;
      end
    end
  end

  // Select and strobe rise on the same edge, so the write ends cleanly.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      CHIP_SEL_N     <= 1'b1;
      OUT_EN_N       <= 1'b1;
      WRITE_N        <= 1'b1;
      BYTE_LINES_OE  <= 1'b0;
      BYTE_LINES_OUT <= 8'h00;
      WORD_ADDRESS   <= 15'h0000;
    end else begin
      CHIP_SEL_N     <= !next_sel;
      OUT_EN_N       <= !next_rd;
      WRITE_N        <= !next_wlow;
      BYTE_LINES_OE  <= next_drive;
      BYTE_LINES_OUT <= take_req ? REQ_WDATA : wdata;
      WORD_ADDRESS   <= take_req ? REQ_ADDR : addr;
    end
  end

  // The byte is sampled while the address is still held, before any change.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      RSP_VALID     <= 1'b0;
      RSP_RDATA     <= 8'h00;
      REQ_READY     <= 1'b0;
      RETAIN_ACTIVE <= 1'b0;
    end else begin
      RSP_VALID     <= rd_done;
      if (rd_done) begin
        RSP_RDATA <= BYTE_LINES_IN;
      end
      REQ_READY     <= (next_state == asp_pkg::ASP_IDLE);
      RETAIN_ACTIVE <= (next_state == asp_pkg::ASP_RETAIN);
    end
  end

  // ===================================================================
  // Checks.
  // ===================================================================
  logic [`ASP_CNT_W-1:0] we_low_cnt;
  logic [`ASP_CNT_W-1:0] ce_low_cnt;
  logic [`ASP_CNT_W-1:0] since_sel;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      we_low_cnt <= 4'h0;
      ce_low_cnt <= 4'h0;
      since_sel  <= 4'hF;
    end else begin
      we_low_cnt <= WRITE_N ? 4'h0 : we_low_cnt + 4'h1;
      ce_low_cnt <= CHIP_SEL_N ? 4'h0 : ce_low_cnt + 4'h1;
      if ($fell(CHIP_SEL_N)) begin
        since_sel <= 4'h1;
      end else if (since_sel != 4'hF) begin
        since_sel <= since_sel + 4'h1;
      end
    end
  end

  sequence wr_strobe_s;
    $fell(WRITE_N) && !BYTE_LINES_OE;
  endsequence

  sequence wr_drive_s;
    !WRITE_N && BYTE_LINES_OE;
  endsequence

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  read_ctrl_a: assert property (!OUT_EN_N |-> WRITE_N && !CHIP_SEL_N)
    else $error("Output enable low outside a read.");
  read_no_drive_a: assert property (!OUT_EN_N |-> !BYTE_LINES_OE)
    else $error("Host drives the lines during a read.");
  write_order_a: assert property (wr_strobe_s |-> ##1 wr_drive_s)
    else $error("Write data not driven one cycle after strobe.");
  // The counters already hold the full low time at the edge that sees the rise.
  write_pulse_a: assert property ($rose(WRITE_N) |-> we_low_cnt >= 4'h2)
    else $error("Write strobe pulse too short.");
  write_sel_a: assert property ($rose(WRITE_N) |-> $rose(CHIP_SEL_N)
                                 && ce_low_cnt >= 4'h2)
    else $error("Chip select too short before write end.");
  access_space_a: assert property ($fell(CHIP_SEL_N) |-> $past(since_sel) >= 4'h2)
    else $error("Accesses closer than the cycle time.");
  read_sample_a: assert property (RSP_VALID |-> $past(!OUT_EN_N, 1) && $past(!OUT_EN_N, 2))
    else $error("Read sampled before output enable time.");
  retain_sel_a: assert property (RETAIN_ACTIVE |-> CHIP_SEL_N && !BYTE_LINES_OE)
    else $error("Chip select low in retention.");
  recover_a: assert property ($fell(RETAIN_ACTIVE) |-> CHIP_SEL_N [*3])
    else $error("Access before recovery time.");

endmodule : asp_host

//--- pkg/asp_params.svh
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// =====================================================================
// Clock and rounding helpers.
// =====================================================================
`define ASP_CLK_PERIOD_NS 50
`define ASP_CEIL_CYC(ns) ((((ns) + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS))
`define ASP_MAX(a, b) (((a) > (b)) ? (a) : (b))

// =====================================================================
// Widths.
// =====================================================================
`define ASP_ADDR_W 15
`define ASP_DATA_W 8
`define ASP_CNT_W  4

// =====================================================================
// Memory timing in nanoseconds, fastest grade.
// =====================================================================
`define ASP_T_RC_NS   85
`define ASP_T_ACC_NS  85
`define ASP_T_CO_NS   85
`define ASP_T_OE_NS   45
`define ASP_T_ODO_NS  30
`define ASP_T_WP_NS   60
`define ASP_T_CW_NS   65
`define ASP_T_WR_NS   5
`define ASP_T_ODW_NS  30
`define ASP_T_DS_NS   40
`define ASP_T_DESELECT_TO_RETENTION_NS 0

// =====================================================================
// Derived cycle counts, all rounded up to whole clocks.
// =====================================================================
`define ASP_RC_CYC `ASP_CEIL_CYC(`ASP_T_RC_NS)
`define ASP_RD_CYC `ASP_MAX(`ASP_MAX(`ASP_RC_CYC, `ASP_CEIL_CYC(`ASP_T_ACC_NS)), \
  `ASP_MAX(`ASP_CEIL_CYC(`ASP_T_CO_NS), `ASP_CEIL_CYC(`ASP_T_OE_NS)))
`define ASP_WZ_CYC `ASP_CEIL_CYC(`ASP_T_ODW_NS)
`define ASP_WP_CYC `ASP_CEIL_CYC(`ASP_T_WP_NS)
`define ASP_CW_CYC `ASP_CEIL_CYC(`ASP_T_CW_NS)
`define ASP_WD_CYC `ASP_MAX(`ASP_CEIL_CYC(`ASP_T_DS_NS), \
  `ASP_MAX(`ASP_WP_CYC - `ASP_WZ_CYC, `ASP_CW_CYC - `ASP_WZ_CYC))
`define ASP_WE_CYC `ASP_MAX(1, `ASP_CEIL_CYC(`ASP_T_WR_NS))
`define ASP_OD_CYC `ASP_CEIL_CYC(`ASP_T_ODO_NS)

`endif

//--- pkg/asp_pkg.sv
package asp_pkg;

  typedef enum logic [6:0] {
    ASP_IDLE    = 7'b000_0001,
    ASP_READ    = 7'b000_0010,
    ASP_WR_SET  = 7'b000_0100,
    ASP_WR_DATA = 7'b000_1000,
    ASP_WR_END  = 7'b001_0000,
    ASP_RETAIN  = 7'b010_0000,
    ASP_RECOVER = 7'b100_0000
  } asp_state_t;

endpackage : asp_pkg

//--- rtl/asp_cycle_timer.sv
`timescale 1ns/10ps
`include "asp_params.svh"

module asp_cycle_timer (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  load,
  input  wire logic [`ASP_CNT_W-1:0] load_val,
  output logic                       last
);

  logic [`ASP_CNT_W-1:0] count;

  // A load of N keeps the state for exactly N cycles; last marks the final one.
  assign last = (count == 4'h1) || (count == 4'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
    end else if (load) begin
      count <= load_val;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end

endmodule : asp_cycle_timer

//--- tb/asp_sram_model.sv
`timescale 1ns/10ps
`include "asp_params.svh"

module asp_sram_model (
  input  wire logic [`ASP_ADDR_W-1:0] addr,
  input  wire logic                   cs_n,
  input  wire logic                   oe_n,
  input  wire logic                   we_n,
  input  wire logic [`ASP_DATA_W-1:0] din,
  input  wire logic                   slow,
  output logic      [`ASP_DATA_W-1:0] dout,
  output logic                        drv
);
  logic [`ASP_DATA_W-1:0] mem [0:32767];
  logic [`ASP_ADDR_W-1:0] a5;
  logic [`ASP_ADDR_W-1:0] a10;
  logic [`ASP_ADDR_W-1:0] a80;
  logic [`ASP_ADDR_W-1:0] pa;
  logic [`ASP_DATA_W-1:0] pd;
  logic                   want;
  logic                   d80;
  logic                   ok;
  logic                   pend;
  assign want = !cs_n && !oe_n && we_n;
  assign #10 drv = want;
  assign #80 d80 = want;
  assign #5 a5 = addr;
  assign #10 a10 = addr;
  assign #80 a80 = addr;
  // Slow answers still settle inside the access time; until then the lines show junk.
  assign ok = slow ? (d80 && a80 == a5) : (a10 == a5);
  assign dout = (ok && drv) ? mem[a5] : ~mem[a5];
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'h00;
    end
    pend = 1'b0;
  end
  // The byte is stored when select or strobe rises first.
  always @(cs_n or we_n or addr or din) begin
    if (!cs_n && !we_n) begin
      pend = 1'b1;
      pa = addr;
      pd = din;
    end else if (pend) begin
      mem[pa] = pd;
      pend = 1'b0;
    end
  end
endmodule : asp_sram_model

//--- tb/async_sram_32k_by_8_port_bench.sv
`timescale 1ns/10ps
`include "asp_params.svh"

module async_sram_32k_by_8_port_bench;
  logic                   clk_sys, reset_n, req_valid, req_write, retain_req, slow;
  logic [`ASP_ADDR_W-1:0] req_addr;
  logic [`ASP_DATA_W-1:0] req_wdata;
  logic                   req_ready, rsp_valid, retain_active, cs_n, oe_n, we_n;
  logic                   bl_oe, mem_drv;
  logic [`ASP_DATA_W-1:0] rsp_rdata, bl_out, bl_in, mem_dout;
  logic [`ASP_ADDR_W-1:0] word_address;
  logic [`ASP_DATA_W-1:0] ref_mem [0:32767];
  logic [`ASP_DATA_W-1:0] exp_q [$];
  int                     errors, compares, seed, wlow;

  assign bl_in = bl_oe ? bl_out : mem_dout;

  asp_host i_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
    .RETAIN_REQ(retain_req), .RETAIN_ACTIVE(retain_active), .WORD_ADDRESS(word_address),
    .CHIP_SEL_N(cs_n), .OUT_EN_N(oe_n), .WRITE_N(we_n), .BYTE_LINES_IN(bl_in),
    .BYTE_LINES_OUT(bl_out), .BYTE_LINES_OE(bl_oe));

  asp_sram_model i_mem (.addr(word_address), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .din(bl_in), .slow(slow), .dout(mem_dout), .drv(mem_drv));

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task req(input logic w, input logic [14:0] a, input logic [7:0] d);
    int k;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (req_ready !== 1'b1 && k < 200);
    if (k >= 200) errors++;
    @(posedge clk_sys);
    #2;
    if (w) ref_mem[a] = d;
    else exp_q.push_back(ref_mem[a]);
  endtask : req

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #1000000;
    errors++;
    test_done();
  end

  // ==========================================================
  // Output watcher.
  // ==========================================================
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) check("rdata", 16'(rsp_rdata), 16'(exp_q.pop_front()));
    if ((bl_oe | mem_drv) === 1'b1) check("clash", 16'(bl_oe & mem_drv), 16'h0000);
    if (cs_n === 1'b0 && oe_n === 1'b0) check("read strobe", 16'(we_n), 16'h0001);
    if (we_n === 1'b0) wlow++;
    else begin
      if (wlow > 0) check("strobe width", 16'(wlow >= 2), 16'h0001);
      wlow = 0;
    end
  end

  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial begin
    logic [31:0] v;
    logic [10:0] hi;
    int          k;
    seed = 12;
    errors = 0;
    compares = 0;
    wlow = 0;
    {reset_n, req_valid, req_write, retain_req, slow} = 5'h00;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    for (int i = 0; i < 32768; i++) ref_mem[i] = 8'h00;
    repeat (20) @(posedge clk_sys);
    check("idle select", 16'(cs_n), 16'h0001);
    check("idle drive", 16'(bl_oe), 16'h0000);
    #2 reset_n = 1'b1;
    req(1'b1, 15'h0000, 8'ha5);
    req(1'b1, 15'h7fff, 8'h5a);
    req(1'b0, 15'h0000, 8'h00);
    req(1'b0, 15'h7fff, 8'h00);
    for (int r = 0; r < 2; r++) begin
      req_valid = 1'b0;
      repeat (5) @(posedge clk_sys);
      #2 slow = r[0];
      v = $random(seed);
      hi = v[10:0];
      for (int i = 0; i < 60; i++) begin
        v = $random(seed);
        req(v[8], {hi, v[3:0]}, v[31:24]);
      end
    end
    req_valid = 1'b0;
    retain_req = 1'b1;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (retain_active !== 1'b1 && k < 8);
    check("retain", 16'(retain_active), 16'h0001);
    check("retain select", 16'(cs_n), 16'h0001);
    @(posedge clk_sys);
    #2 retain_req = 1'b0;
    repeat (3) begin
      @(negedge clk_sys);
      check("recovery", 16'({cs_n, req_ready}), 16'h0002);
    end
    @(posedge clk_sys);
    #2 check("recovered", 16'(req_ready), 16'h0001);
    req(1'b0, 15'h0000, 8'h00);
    req(1'b0, 15'h7fff, 8'h00);
    req_valid = 1'b0;
    repeat (6) @(posedge clk_sys);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    test_done();
  end
endmodule : async_sram_32k_by_8_port_bench
